// File: verilog/cps_status.sv
`timescale 1ns/1ns
`include "cps_consts.svh"

// Overview of operation
// R1: 8-bit read-only status byte at 12h
// R2: bits 6 and 5 always read zero
// R3: no-handshake set only in dedicated cycle
// R4: new profile applied clears no-handshake
// R5: profile ends unshaken sets no-handshake
// R6: no-handshake excludes every other profile bit
// R7: cleared no-handshake does not mean charging
// R8: undervoltage flag set, power switch held off
// R9: undervoltage flag clears above lockout threshold
// R10: custom flag on custom handshake while charging
// R11: custom profile drives high-speed switch setting
// R12: custom profile selects current-limit behaviour
// R13: DCP flag on accepted DCP while charging
// R14: DCP switch follows dedicated switch control
// R15: DCP uses constant-current limiting
// R16: pass-through flag not reset after reattach
// R17: first mode-select toggle re-arms pass-through
// R18: power off, mode change, removal clear profiles
// R19: flags never drive alert or attach outputs
// R20: CDP flag, switch closed, trip limiting
// R21: pass-through flag, switch closed, trip limiting
// R22: writes ignored, reads have no side effect
// R23: status byte coherent, updated on clock

module cps_status
  import cps_pkg::*;
(
  // clock, enable and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // pins from outside the clock domain
  input wire cps_pins_s i_pins,
  // emulation engine and configuration
  input wire cps_engine_s i_engine,
  input wire cps_cfg_s i_cfg,
  // register access from the management port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  output cps_byte_t o_reg_rdata,
  output logic o_reg_ack,
  // port controls and status view
  output logic o_hs_switch_closed,
  output logic o_cc_limit_mode,
  output logic o_port_switch_hold_off,
  output cps_byte_t o_status
);

  // pass-through indication arming
  typedef enum logic [1:0] {
    CPS_THRU_ARMED,
    CPS_THRU_SHOWN,
    CPS_THRU_SPENT
  } cps_thru_e;

  // true when the engine reports acceptance of a given profile while charging
  function automatic logic prof_hit(input cps_engine_s ev, input cps_prof_e prof);
    prof_hit = ev.accepted && (ev.accepted_prof == prof) && ev.charging;
  endfunction : prof_hit

  // synchronised pins and their history
  cps_pins_s pins_s;
  cps_mode_e mode_q;
  logic msel_q;

  // clearing causes
  logic mode_change;
  logic msel_toggle;
  logic power_off;
  logic profile_clear;

  // pass-through arming state
  cps_thru_e thru_state_q;
  cps_thru_e thru_state_d;

  // set and clear requests
  logic set_custom;
  logic set_dcp;
  logic set_cdp;
  logic set_thru;
  logic any_prof_set;
  logic set_unshaken;
  logic clr_unshaken;

  // held flags
  logic custom_flag;
  logic dcp_flag;
  logic cdp_flag;
  logic thru_flag;
  logic unshaken_flag;
  logic undervolt_q;

  // status byte and port controls
  logic hs_d;
  logic cc_d;
  cps_byte_t status_d;
  cps_byte_t status_q;
  logic hs_q;
  logic cc_q;
  logic hold_q;

  // register port
  logic status_sel;
  cps_byte_t rdata_q;
  logic ack_q;

  // pins pass two flops before anything reads them
  cps_sync u_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_pins(i_pins),
    .o_pins(pins_s)
  );

  // registered mode, so a new selection shows as a one-cycle change
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_q <= CPS_MODE_PASSTHROUGH;
    end else if (i_clk_en) begin
      mode_q <= i_cfg.active_mode;
    end
  end

  // last first mode-select level; resets to the pin's idle low, no false toggle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      msel_q <= 1'b0;
    end else if (i_clk_en) begin
      msel_q <= pins_s.mode_select_first;
    end
  end

  // clearing causes shared by the four profile flags
  assign mode_change = (i_cfg.active_mode != mode_q);
  assign msel_toggle = (pins_s.mode_select_first != msel_q); // R17
  // a level, so flags stay clear while power is off unless a set request arrives
  assign power_off = !pins_s.port_power_enable;
  assign profile_clear = power_off || mode_change || i_engine.removal; // R18

  // custom only counts inside the dedicated cycle
  assign set_custom = prof_hit(i_engine, CPS_PROF_CUSTOM)
                      && i_engine.dedicated_emulation_cycle; // R10
  assign set_dcp = prof_hit(i_engine, CPS_PROF_DCP); // R13
  assign set_cdp = prof_hit(i_engine, CPS_PROF_CDP); // R20

  // pass-through arming; a plain reattach does not re-arm
  always_comb begin
    thru_state_d = thru_state_q;
    case (thru_state_q)
      CPS_THRU_ARMED: begin
        if (i_cfg.active_mode == CPS_MODE_PASSTHROUGH && pins_s.port_power_enable
            && !i_engine.removal) begin
          thru_state_d = CPS_THRU_SHOWN; // R21
        end
      end
      CPS_THRU_SHOWN: begin
        if (i_engine.removal) begin
          thru_state_d = CPS_THRU_SPENT; // R16
        end else if (mode_change || power_off) begin
          thru_state_d = CPS_THRU_ARMED;
        end
      end
      CPS_THRU_SPENT: begin
        if (msel_toggle || mode_change) begin
          thru_state_d = CPS_THRU_ARMED; // R17
        end
      end
      default: begin
        thru_state_d = CPS_THRU_ARMED;
      end
    endcase
  end

  // arming state register
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      thru_state_q <= CPS_THRU_ARMED;
    end else if (i_clk_en) begin
      thru_state_q <= thru_state_d;
    end
  end

  // the flag rises as the arming state moves to shown
  assign set_thru = (thru_state_q == CPS_THRU_ARMED)
                    && (thru_state_d == CPS_THRU_SHOWN); // R21

  // one sticky flag per handshake outcome
  cps_flag u_custom (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_set(set_custom),
    .i_clear(profile_clear),
    .o_flag(custom_flag)
  );

  cps_flag u_dcp (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_set(set_dcp),
    .i_clear(profile_clear),
    .o_flag(dcp_flag)
  );

  cps_flag u_cdp (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_set(set_cdp),
    .i_clear(profile_clear),
    .o_flag(cdp_flag)
  );

  cps_flag u_thru (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_set(set_thru),
    .i_clear(profile_clear),
    .o_flag(thru_flag)
  );

  // no-handshake is blocked by any profile bit, present or arriving
  assign any_prof_set = custom_flag || dcp_flag || cdp_flag || thru_flag
                        || set_custom || set_dcp || set_cdp || set_thru; // R6
  assign set_unshaken = i_engine.profile_end_unshaken && i_engine.dedicated_emulation_cycle
                        && !any_prof_set; // R3 R5
  // clearing means only that a profile was applied, not that charge flows
  assign clr_unshaken = i_engine.profile_applied || any_prof_set; // R4 R7

  cps_flag u_unshaken (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_set(set_unshaken),
    .i_clear(clr_unshaken),
    .o_flag(unshaken_flag)
  );

  // undervoltage flag tracks the synchronised comparator level
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      undervolt_q <= 1'b0;
    end else if (i_clk_en) begin
      undervolt_q <= pins_s.source_below_lockout; // R8 R9
    end
  end

  // switch and current-limit choice per accepted profile
  always_comb begin
    hs_d = 1'b0;
    cc_d = 1'b0;
    if (custom_flag) begin
      hs_d = i_cfg.custom_hs_close; // R11
      cc_d = i_cfg.custom_cc_limit; // R12
    end else if (dcp_flag) begin
      hs_d = i_cfg.dedicated_hs_switch_ctl; // R14
      cc_d = 1'b1; // R15
    end else if (cdp_flag || thru_flag) begin
      hs_d = 1'b1; // R20 R21
      cc_d = 1'b0;
    end
  end

  // assemble the status byte; spare bits are tied low
  always_comb begin
    status_d = `CPS_STATUS_RESET;
    status_d[`CPS_BIT_NO_HANDSHAKE] = unshaken_flag;
    status_d[`CPS_BIT_SPARE_HI] = 1'b0; // R2
    status_d[`CPS_BIT_SPARE_LO] = 1'b0; // R2
    status_d[`CPS_BIT_SOURCE_UNDERVOLT] = undervolt_q;
    status_d[`CPS_BIT_CUSTOM] = custom_flag;
    status_d[`CPS_BIT_DCP] = dcp_flag;
    status_d[`CPS_BIT_CDP] = cdp_flag;
    status_d[`CPS_BIT_PASSTHROUGH] = thru_flag; // R1
  end

  // snapshot each cycle so a read sees one coherent byte
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      status_q <= `CPS_STATUS_RESET;
    end else if (i_clk_en) begin
      status_q <= status_d; // R23
    end
  end

  // switch and limit follow the profile; undervoltage forces the switch open
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      hs_q <= 1'b0;
      cc_q <= 1'b0;
    end else if (i_clk_en) begin
      hs_q <= hs_d && !undervolt_q; // R19
      cc_q <= cc_d;
    end
  end

  // power switch hold-off; nothing here feeds alert or attach pins
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_q <= 1'b0;
    end else if (i_clk_en) begin
      hold_q <= undervolt_q; // R8
    end
  end

  // only one register is mapped on the management port
  assign status_sel = (i_reg_addr == `CPS_ADDR_PROFILE_STATUS_ONE);

  // every access is acknowledged next cycle; writes are dropped
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
    end else if (i_clk_en) begin
      ack_q <= i_reg_rd || i_reg_wr; // R22
    end
  end

  // reads copy the snapshot and never touch a flag
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= `CPS_STATUS_RESET;
    end else if (i_clk_en && i_reg_rd) begin
      if (status_sel) begin
        rdata_q <= status_q; // R1 R23
      end else begin
        rdata_q <= `CPS_STATUS_RESET; // unmapped reads give zero
      end
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_ack = ack_q;
  assign o_hs_switch_closed = hs_q;
  assign o_cc_limit_mode = cc_q;
  assign o_port_switch_hold_off = hold_q;
  assign o_status = status_q;

endmodule : cps_status

// File: verilog/cps_consts.svh
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

// register map of the management port
`define CPS_ADDR_PROFILE_STATUS_ONE 8'h12
`define CPS_STATUS_RESET 8'h00

// field positions inside the status byte
`define CPS_BIT_NO_HANDSHAKE 7
`define CPS_BIT_SPARE_HI 6
`define CPS_BIT_SPARE_LO 5
`define CPS_BIT_SOURCE_UNDERVOLT 4
`define CPS_BIT_CUSTOM 3
`define CPS_BIT_DCP 2
`define CPS_BIT_CDP 1
`define CPS_BIT_PASSTHROUGH 0

// synchroniser depth for pin inputs
`define CPS_SYNC_STAGES 2

`endif

// File: verilog/cps_pkg.sv
package cps_pkg;

  // active mode chosen by configuration
  typedef enum logic [1:0] {
    CPS_MODE_PASSTHROUGH,
    CPS_MODE_DCP,
    CPS_MODE_CDP,
    CPS_MODE_DEDICATED_CYCLE
  } cps_mode_e;

  // profile that the portable device accepted
  typedef enum logic [1:0] {
    CPS_PROF_NONE,
    CPS_PROF_CUSTOM,
    CPS_PROF_DCP,
    CPS_PROF_CDP
  } cps_prof_e;

  // events from the emulation engine, same clock
  typedef struct packed {
    logic dedicated_emulation_cycle;
    logic profile_applied;
    logic profile_end_unshaken;
    logic accepted;
    cps_prof_e accepted_prof;
    logic charging;
    logic removal;
  } cps_engine_s;

  // configuration settings, same clock
  typedef struct packed {
    cps_mode_e active_mode;
    logic custom_hs_close;
    logic custom_cc_limit;
    logic dedicated_hs_switch_ctl;
  } cps_cfg_s;

  // asynchronous pin levels
  typedef struct packed {
    logic source_below_lockout;
    logic port_power_enable;
    logic mode_select_first;
  } cps_pins_s;

  typedef logic [7:0] cps_byte_t;

endpackage : cps_pkg

// File: verilog/cps_sync.sv
`timescale 1ns/1ns
`include "cps_consts.svh"

module cps_sync
  import cps_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // pin levels in and out
  input wire cps_pins_s i_pins,
  output cps_pins_s o_pins
);

  cps_pins_s stage_q [`CPS_SYNC_STAGES];

  // two flops per pin; only the last stage is read
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < `CPS_SYNC_STAGES; i++) begin
        stage_q[i] <= '0;
      end
    end else if (i_clk_en) begin
      stage_q[0] <= i_pins;
      for (int i = 1; i < `CPS_SYNC_STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign o_pins = stage_q[`CPS_SYNC_STAGES-1];

endmodule : cps_sync

// File: verilog/cps_flag.sv
`timescale 1ns/1ns

module cps_flag (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // set and clear requests
  input wire logic i_set,
  input wire logic i_clear,
  // held flag
  output logic o_flag
);

  logic flag_q;

  // set wins so an event in the clear cycle is kept
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_q <= 1'b0;
    end else if (i_clk_en) begin
      if (i_set) begin
        flag_q <= 1'b1;
      end else if (i_clear) begin
        flag_q <= 1'b0;
      end
    end
  end

  assign o_flag = flag_q;

endmodule : cps_flag

// File: sim/cps_status_assertions.sv
`timescale 1ns/1ns

module cps_status_assertions
  import cps_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // inputs seen by the device
  input wire cps_engine_s i_engine,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  // device outputs
  input wire cps_byte_t o_reg_rdata,
  input wire logic o_reg_ack,
  input wire logic o_hs_switch_closed,
  input wire logic o_cc_limit_mode,
  input wire logic o_port_switch_hold_off,
  input wire cps_byte_t o_status
);
  // single domain, so one default for all
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // a taken read of the status byte
  sequence rd_status;
    i_clk_en && i_reg_rd && i_reg_addr == 8'h12;
  endsequence
  // removal without a competing set, then one enabled cycle
  sequence rm_taken;
    i_clk_en && i_engine.removal && !i_engine.accepted ##1 i_clk_en;
  endsequence

  spare_zero_a: assert property (o_status[6:5] == 2'h0)
    else $error("spare status bits set");
  unshaken_alone_a: assert property (o_status[7] |-> o_status[3:0] == 4'h0)
    else $error("no-handshake flag beside a profile flag");
  ack_follows_a: assert property ((i_reg_rd || i_reg_wr) && i_clk_en |=> o_reg_ack)
    else $error("register access not acknowledged");
  rdata_status_a: assert property (rd_status |=> o_reg_rdata == $past(o_status))
    else $error("read data differs from status byte");
  rdata_unmapped_a: assert property (
    i_clk_en && i_reg_rd && i_reg_addr != 8'h12 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  uv_holdoff_a: assert property ($rose(o_status[4]) |-> ##[0:2] o_port_switch_hold_off)
    else $error("power switch not held off in undervoltage");
  dcp_cc_a: assert property (o_status[2] |-> o_cc_limit_mode)
    else $error("dcp without constant-current limiting");
  trip_closed_a: assert property (
    (o_status[1] || o_status[0]) && !o_status[4] |-> o_hs_switch_closed && !o_cc_limit_mode)
    else $error("cdp or pass-through switch setting wrong");
  removal_clear_a: assert property (rm_taken |=> o_status[3:0] == 4'h0)
    else $error("profile flags survive removal");
endmodule : cps_status_assertions

bind cps_status cps_status_assertions cps_status_assertions_inst (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_engine(i_engine),
  .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
  .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_hs_switch_closed(o_hs_switch_closed),
  .o_cc_limit_mode(o_cc_limit_mode), .o_port_switch_hold_off(o_port_switch_hold_off),
  .o_status(o_status));

// File: sim/cps_host_model.sv
`timescale 1ns/1ns

module cps_host_model (
  // clock
  input wire logic i_clock,
  // request from the bench
  input wire logic i_go,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  // device register port
  input wire logic [7:0] i_rdata,
  input wire logic i_ack,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_data,
  output logic o_done
);
  // quiet bus at time zero
  initial begin
    {o_rd, o_wr, o_done} = 3'h0;
    {o_addr, o_data} = 16'h0000;
  end
  // one strobe per request; address held until the ack edge, then scrambled
  always @(posedge i_clock) begin
    o_done <= i_ack;
    o_rd <= i_go & ~i_wr;
    o_wr <= i_go & i_wr;
    if (i_go) begin
      o_addr <= i_addr;
    end
    if (i_ack) begin
      o_data <= i_rdata;
      o_addr <= ~o_addr;
    end
  end
endmodule : cps_host_model

// File: sim/tb.sv
`timescale 1ns/1ns

module tb;
  import cps_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic go = 1'h0;
  logic en = 1'h1;
  logic wr = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] ra;
  cps_pins_s pins;
  cps_engine_s eng;
  cps_cfg_s cfg;
  logic rd_s, wr_s, ack, done, hs, cc, hold;
  logic [7:0] a_s, rdata, hdata;
  cps_byte_t st;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'hd89d_8878;

  cps_status cps_status_inst (.i_clock(clk), .i_resetn(rst_n), .i_clk_en(en), .i_pins(pins),
    .i_engine(eng), .i_cfg(cfg), .i_reg_addr(a_s), .i_reg_rd(rd_s), .i_reg_wr(wr_s),
    .o_reg_rdata(rdata), .o_reg_ack(ack), .o_hs_switch_closed(hs), .o_cc_limit_mode(cc),
    .o_port_switch_hold_off(hold), .o_status(st));
  cps_host_model cps_host_model_inst (.i_clock(clk), .i_go(go), .i_wr(wr), .i_addr(addr),
    .i_rdata(rdata), .i_ack(ack), .o_rd(rd_s), .o_wr(wr_s), .o_addr(a_s), .o_data(hdata),
    .o_done(done));

  // 100 MHz
  always #5 clk = ~clk;

  // read data expected from an address: only the status byte is mapped
  function automatic cps_byte_t exp_rd(input logic [7:0] a, input cps_byte_t s);
    return (a == 8'h12) ? s : 8'h00;
  endfunction : exp_rd

  task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic close_out();
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // one host access; bounded wait so a lost ack cannot hang the run
  task automatic acc(input logic w, input logic [7:0] a, input cps_byte_t e);
    int n;
    n = 0;
    {go, wr, addr} = {1'h1, w, a};
    wt(1);
    go = 1'h0;
    while (done !== 1'h1 && n < 20) begin
      wt(1);
      n++;
    end
    if (!w) begin
      chk("rdata", hdata, e);
    end
  endtask : acc

  // one-cycle engine event, then let the status copy settle
  task automatic pulse(input logic [3:0] p, input cps_prof_e pr);
    {eng.profile_applied, eng.profile_end_unshaken, eng.accepted, eng.removal} = p;
    eng.accepted_prof = pr;
    wt(1);
    {eng.profile_applied, eng.profile_end_unshaken, eng.accepted, eng.removal} = 4'h0;
    wt(3);
  endtask : pulse

  // watchdog, far beyond the expected run
  initial begin
    #200000;
    err_total++;
    close_out();
  end

  initial begin
    pins = '0;
    pins.port_power_enable = 1'h1;
    eng = '0;
    eng.charging = 1'h1;
    cfg = '0;
    cfg.active_mode = CPS_MODE_DCP;
    wt(16);
    rst_n = 1'h1;
    wt(2);
    acc(0, 8'h12, 8'h00);
    acc(0, 8'h13, 8'h00);
    cfg.dedicated_hs_switch_ctl = 1'($random(seed));
    pulse(4'h2, CPS_PROF_DCP);
    chk("dcp", {st, hs, cc}, {8'h04, cfg.dedicated_hs_switch_ctl, 1'h1});
    acc(1, 8'h12, 8'h00);
    acc(0, 8'h12, 8'h04);
    pulse(4'h1, CPS_PROF_NONE);
    chk("removal", st, 8'h00);
    pulse(4'h2, CPS_PROF_CDP);
    chk("cdp", {st, hs, cc}, {8'h02, 2'h2});
    cfg.active_mode = CPS_MODE_DEDICATED_CYCLE;
    wt(4);
    chk("mode", st, 8'h00);
    eng.dedicated_emulation_cycle = 1'h1;
    {cfg.custom_hs_close, cfg.custom_cc_limit} = 2'($random(seed));
    pulse(4'h2, CPS_PROF_CUSTOM);
    chk("custom", {st, hs, cc}, {8'h08, cfg.custom_hs_close, cfg.custom_cc_limit});
    pulse(4'h1, CPS_PROF_NONE);
    pulse(4'h4, CPS_PROF_NONE);
    chk("unshaken", st, 8'h80);
    acc(0, 8'h12, 8'h80);
    pulse(4'h8, CPS_PROF_NONE);
    chk("applied", st, 8'h00);
    eng.dedicated_emulation_cycle = 1'h0;
    pulse(4'h4, CPS_PROF_NONE);
    chk("outside", st, 8'h00);
    en = 1'h0;
    pins.source_below_lockout = 1'h1;
    wt(6);
    chk("frozen", {st, hold}, {8'h00, 1'h0});
    en = 1'h1;
    wt(6);
    chk("uv", {st, hold}, {8'h10, 1'h1});
    pins.source_below_lockout = 1'h0;
    wt(6);
    chk("uv_off", st, 8'h00);
    cfg.active_mode = CPS_MODE_PASSTHROUGH;
    wt(4);
    chk("thru", {st, hs, cc}, {8'h01, 2'h2});
    // random addresses, every other one the status byte
    for (int i = 0; i < 8; i++) begin
      ra = i[0] ? 8'h12 : 8'($random(seed));
      acc(0, ra, exp_rd(ra, 8'h01));
    end
    pulse(4'h1, CPS_PROF_NONE);
    wt(4);
    chk("thru_rem", st, 8'h00);
    pins.mode_select_first = 1'h1;
    wt(6);
    chk("thru_rearm", st, 8'h01);
    pins.port_power_enable = 1'h0;
    wt(6);
    chk("pwr_off", st, 8'h00);
    close_out();
  end
endmodule : tb
